//--- core/aux_input_ctrl.sv
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module aux_input_ctrl #(
  parameter int unsigned TICK_CYCLES = aux_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] auxiliary_contact_inputs,
  output var aux_pkg::ctrl_out_t control,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int unsigned SPW = aux_pkg::SP_W;
  localparam int unsigned FW = aux_pkg::FSEL_W;
  localparam int unsigned EW = aux_pkg::EV_W;
  localparam logic [aux_pkg::TICK_W-1:0] TICK_LAST = aux_pkg::TICK_W'(TICK_CYCLES - 1);

  logic [4*FW-1:0] input_function_select;
  logic [4*FW-1:0] next_func;
  logic [SPW-1:0] main_pressure_setpoint;
  logic [SPW-1:0] next_main;
  logic [SPW-1:0] auxiliary_pressure_setpoint [4];
  logic [SPW-1:0] next_aux [4];
  logic [EW-1:0] status;
  logic [EW-1:0] next_status;
  logic [EW-1:0] mask;
  logic [EW-1:0] next_mask;
  logic [EW-1:0] snap;
  logic [EW-1:0] next_snap;
  logic [31:0] next_prdata;
  logic [aux_pkg::TICK_W-1:0] tick_cnt;
  logic [aux_pkg::TICK_W-1:0] next_tick_cnt;
  logic tick;
  aux_pkg::func_t fn [4];
  logic [3:0] raw;
  logic [3:0] clr;
  logic [3:0] qual;
  logic [3:0] qual_d;
  logic [3:0] aux_q;
  logic [3:0] dis_q;
  logic [3:0] rst_rise;
  logic aux_any_d;
  logic dis_any_d;
  logic [EW-1:0] events;
  logic [SPW-1:0] best_sp;
  logic [2:0] best_idx;
  aux_pkg::ctrl_out_t next_control;
  logic setup;
  logic access;
  logic known;

  // ----------------------------------------
  // Input decoding
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_in
      // RL1 per-input code
      assign fn[gi] = aux_pkg::decode(input_function_select[gi*FW +: FW]);
      // RL2 unused codes cleared
      assign clr[gi] = !(fn[gi].aux || fn[gi].dis || fn[gi].rst);
      // RL5 RL11 contact polarity
      assign raw[gi] = !clr[gi] && (auxiliary_contact_inputs[gi] ^ fn[gi].inv);
      persist_qual u_qual (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(tick),
        .clr(clr[gi]),
        .raw(raw[gi]),
        .qual(qual[gi])
      );
      // RL3 setpoint index follows input
      assign aux_q[gi] = qual[gi] && fn[gi].aux;
      // RL10 disable codes
      assign dis_q[gi] = qual[gi] && fn[gi].dis;
      // RL15 RL16 reset on activation
      assign rst_rise[gi] = qual[gi] && !qual_d[gi] && fn[gi].rst;
    end
  endgenerate

  // ----------------------------------------
  // Tick prescaler
  // ----------------------------------------
  // RL17 shared time base
  assign tick = (tick_cnt == TICK_LAST);

  always_comb begin
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else if (ce) begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ----------------------------------------
  // Setpoint selection
  // ----------------------------------------
  // RL9 lowest active wins, lower index on ties
  always_comb begin
    best_sp = main_pressure_setpoint;
    best_idx = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (aux_q[i] && (best_idx == 3'h0 || auxiliary_pressure_setpoint[i] < best_sp)) begin
        best_sp = auxiliary_pressure_setpoint[i];
        best_idx = 3'(i + 1);
      end
    end
  end

  // ----------------------------------------
  // Control outputs and events
  // ----------------------------------------
  always_comb begin
    // RL4 RL8 setpoint and index
    next_control.setpoint = best_sp;
    next_control.auxiliary_setpoint_indication = best_idx;
    // RL10 RL12 RL13 RL14 disable state
    next_control.motor_disable = |dis_q;
    next_control.system_disabled_indication = |dis_q;
    // RL15 RL16 one-cycle reset pulse
    next_control.fault_reset = |rst_rise;
    events = '0;
    events[aux_pkg::EV_AUX_ON] = (|aux_q) && !aux_any_d;
    events[aux_pkg::EV_AUX_OFF] = !(|aux_q) && aux_any_d;
    events[aux_pkg::EV_DIS_ON] = (|dis_q) && !dis_any_d;
    events[aux_pkg::EV_DIS_OFF] = !(|dis_q) && dis_any_d;
    events[aux_pkg::EV_RST] = |rst_rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= '0;
      qual_d <= '0;
      aux_any_d <= 1'b0;
      dis_any_d <= 1'b0;
    end else if (ce) begin
      control <= next_control;
      qual_d <= qual;
      aux_any_d <= |aux_q;
      dis_any_d <= |dis_q;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Read data is latched in setup, so with ce high every access has one wait-free access cycle
  assign setup = ce && psel && !penable;
  assign access = ce && psel && penable;
  assign pready = ce;
  assign pslverr = access && !known;
  assign irq = |(status & mask);

  always_comb begin
    known = 1'b0;
    if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'h0) begin
      known = 1'b0;
    end else if (paddr[7:0] == aux_pkg::ADDR_FUNC_SEL) begin
      known = 1'b1;
    end else if (paddr[7:0] == aux_pkg::ADDR_MAIN_SP) begin
      known = 1'b1;
    end else if (paddr[7:0] >= aux_pkg::ADDR_AUX_SP0 && paddr[7:0] < aux_pkg::ADDR_STATUS) begin
      known = 1'b1;
    end else if (paddr[7:0] == aux_pkg::ADDR_STATUS) begin
      known = 1'b1;
    end else if (paddr[7:0] == aux_pkg::ADDR_MASK) begin
      known = 1'b1;
    end else if (paddr[7:0] == aux_pkg::ADDR_STATE) begin
      known = 1'b1;
    end
  end

  always_comb begin
    next_prdata = prdata;
    next_snap = snap;
    if (setup) begin
      next_prdata = '0;
      next_snap = '0;
      if (!known) begin
        next_prdata = '0;
      end else if (paddr[7:0] == aux_pkg::ADDR_FUNC_SEL) begin
        next_prdata[4*FW-1:0] = input_function_select;
      end else if (paddr[7:0] == aux_pkg::ADDR_MAIN_SP) begin
        next_prdata[SPW-1:0] = main_pressure_setpoint;
      end else if (paddr[7:0] >= aux_pkg::ADDR_AUX_SP0 && paddr[7:0] < aux_pkg::ADDR_STATUS) begin
        next_prdata[SPW-1:0] = auxiliary_pressure_setpoint[paddr[3:2] - 2'h2];
      end else if (paddr[7:0] == aux_pkg::ADDR_STATUS) begin
        next_prdata[EW-1:0] = status;
        next_snap = status;
      end else if (paddr[7:0] == aux_pkg::ADDR_MASK) begin
        next_prdata[EW-1:0] = mask;
      end else begin
        next_prdata[aux_pkg::ST_QUAL_LSB +: 4] = qual;
        next_prdata[aux_pkg::ST_IN_LSB +: 4] = auxiliary_contact_inputs;
        next_prdata[aux_pkg::ST_IND_LSB +: 3] = control.auxiliary_setpoint_indication;
        next_prdata[aux_pkg::ST_DIS_BIT] = control.system_disabled_indication;
      end
    end
  end

  always_comb begin
    next_func = input_function_select;
    next_main = main_pressure_setpoint;
    next_mask = mask;
    for (int i = 0; i < 4; i++) begin
      next_aux[i] = auxiliary_pressure_setpoint[i];
    end
    // Only the bits shown by the read are cleared; a new event always sets
    next_status = status;
    if (access && !pwrite && known && paddr[7:0] == aux_pkg::ADDR_STATUS) begin
      next_status = status & ~snap;
    end
    next_status = next_status | events;
    if (access && pwrite && known) begin
      if (paddr[7:0] == aux_pkg::ADDR_FUNC_SEL) begin
        next_func = pwdata[4*FW-1:0];
      end else if (paddr[7:0] == aux_pkg::ADDR_MAIN_SP) begin
        next_main = pwdata[SPW-1:0];
      end else if (paddr[7:0] >= aux_pkg::ADDR_AUX_SP0 && paddr[7:0] < aux_pkg::ADDR_STATUS) begin
        next_aux[paddr[3:2] - 2'h2] = pwdata[SPW-1:0];
      end else if (paddr[7:0] == aux_pkg::ADDR_MASK) begin
        next_mask = pwdata[EW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_function_select <= aux_pkg::FUNC_SEL_RESET;
      main_pressure_setpoint <= aux_pkg::MAIN_SP_RESET;
      for (int i = 0; i < 4; i++) begin
        auxiliary_pressure_setpoint[i] <= aux_pkg::AUX_SP_RESET;
      end
      status <= '0;
      mask <= aux_pkg::MASK_RESET;
      snap <= '0;
      prdata <= '0;
    end else if (ce) begin
      input_function_select <= next_func;
      main_pressure_setpoint <= next_main;
      for (int i = 0; i < 4; i++) begin
        auxiliary_pressure_setpoint[i] <= next_aux[i];
      end
      status <= next_status;
      mask <= next_mask;
      snap <= next_snap;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_main_sp;
    @(posedge pclk) disable iff (!presetn)
    (ce && aux_q == 4'h0) |=> (control.setpoint == $past(main_pressure_setpoint));
  endproperty
  a_main_sp: assert property (p_main_sp) else $error("main setpoint not used"); // RL4

  property p_ind_idx;
    @(posedge pclk) disable iff (!presetn)
    (control.auxiliary_setpoint_indication != 3'h0) |->
      (($past(aux_q) >> (control.auxiliary_setpoint_indication - 3'h1)) & 4'h1) != 4'h0;
  endproperty
  a_ind_idx: assert property (p_ind_idx) else $error("index of idle input shown"); // RL3

  property p_ind_off;
    @(posedge pclk) disable iff (!presetn)
    (ce && aux_q == 4'h0) |=> (control.auxiliary_setpoint_indication == 3'h0);
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("indication without request"); // RL8

  property p_lowest;
    @(posedge pclk) disable iff (!presetn)
    (ce && aux_q[1] && aux_q[2]) |=> (control.setpoint <= $past(auxiliary_pressure_setpoint[1])
      && control.setpoint <= $past(auxiliary_pressure_setpoint[2]));
  endproperty
  a_lowest: assert property (p_lowest) else $error("setpoint not the lowest"); // RL9

  property p_dis_ind;
    @(posedge pclk) disable iff (!presetn)
    ce |=> (control.system_disabled_indication == $past(|dis_q)
      && control.motor_disable == control.system_disabled_indication);
  endproperty
  a_dis_ind: assert property (p_dis_ind) else $error("disable indication wrong"); // RL14

  sequence s_dis_rst_rise;
    ce && fn[0].dis && fn[0].rst && qual[0] && !qual_d[0];
  endsequence
  property p_dis_rst;
    @(posedge pclk) disable iff (!presetn)
    s_dis_rst_rise |=> (control.fault_reset && control.motor_disable) ##1 !control.fault_reset [*2];
  endproperty
  a_dis_rst: assert property (p_dis_rst) else $error("reset with disable missing"); // RL15

  property p_rst_only;
    @(posedge pclk) disable iff (!presetn)
    (ce && qual[1] && input_function_select[2*FW-1:FW] == aux_pkg::FN_RST_NO
      && ((dis_q | aux_q) & 4'hd) == 4'h0) |=>
      (!control.motor_disable && control.auxiliary_setpoint_indication == 3'h0);
  endproperty
  a_rst_only: assert property (p_rst_only) else $error("code 9 acted beyond reset"); // RL16

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
    (input_function_select[4*FW-1:3*FW] == aux_pkg::FN_DIS_NC) |->
      (raw[3] == !auxiliary_contact_inputs[3]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("closed-contact polarity wrong"); // RL11

  property p_aux_pol;
    @(posedge pclk) disable iff (!presetn)
    (input_function_select[2*FW-1:FW] == aux_pkg::FN_AUX_NO) |->
      (raw[1] == auxiliary_contact_inputs[1]);
  endproperty
  a_aux_pol: assert property (p_aux_pol) else $error("open-contact polarity wrong"); // RL5

  property p_dis_entry;
    @(posedge pclk) disable iff (!presetn)
    $rose(control.motor_disable) |-> $past(dis_any_d == 1'b0 && tick, 2);
  endproperty
  a_dis_entry: assert property (p_dis_entry) else $error("disable without qualified second"); // RL12

  property p_dis_exit;
    @(posedge pclk) disable iff (!presetn)
    // A change to an unused code clears the qualifier on the same edge as the output falls
    ($fell(control.motor_disable) && $past(input_function_select, 3) == input_function_select)
      |-> $past(tick, 2);
  endproperty
  a_dis_exit: assert property (p_dis_exit) else $error("re-enable without qualified second"); // RL13

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (ce && events[aux_pkg::EV_RST] && mask[aux_pkg::EV_RST] && !(pwrite && access)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event gave no interrupt"); // RL16

endmodule : aux_input_ctrl
`default_nettype wire

//--- common/aux_pkg.sv
// Function
// RL1 - Each of the four inputs has its own function code and any code suits any input.
// RL2 - Code 0 makes the input ignored whatever its level.
// RL3 - Codes 3 and 4 make input i request auxiliary setpoint i.
// RL4 - An active auxiliary request replaces the main setpoint by that auxiliary setpoint.
// RL5 - Code 3 requests when the input is present, code 4 when it is absent.
// RL6 - The auxiliary setpoint is taken only after the request held for one second.
// RL7 - The main setpoint returns only after the request was absent for one second.
// RL8 - The auxiliary indication shows the index in use and clears with no request.
// RL9 - With several requests the lowest requested auxiliary pressure is used.
// RL10 - Codes 5 to 8 disable the whole system and show the disabled indication.
// RL11 - Codes 5 and 7 disable on a present input, codes 6 and 8 on an absent one.
// RL12 - Disabling starts only after the request held for one second.
// RL13 - Re-enabling happens only after the request was absent for one second.
// RL14 - The disabled indication stands while any disable input is active.
// RL15 - Codes 7 and 8 also reset resettable faults when disabling begins.
// RL16 - Code 9 resets faults on a present input with no disable and no indication.
// RL17 - Each input times its second on a counter of clock ticks that restarts on change.
package aux_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
  localparam int unsigned TICK_W = 16;
  localparam int unsigned QUAL_TIME_S = 1;
  localparam int unsigned QUAL_TICKS = QUAL_TIME_S * 1000000 / TICK_TIME_US;
  localparam int unsigned QCNT_W = 10;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_FUNC_SEL = 8'h00;
  localparam logic [7:0] ADDR_MAIN_SP = 8'h04;
  localparam logic [7:0] ADDR_AUX_SP0 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1c;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  localparam logic [15:0] FUNC_SEL_RESET = 16'h0000;
  localparam logic [15:0] MAIN_SP_RESET = 16'h0000;
  localparam logic [15:0] AUX_SP_RESET = 16'h0000;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam int unsigned FSEL_W = 4;
  localparam int unsigned SP_W = 16;

  // Status and mask bits
  localparam int unsigned EV_AUX_ON = 0;
  localparam int unsigned EV_AUX_OFF = 1;
  localparam int unsigned EV_DIS_ON = 2;
  localparam int unsigned EV_DIS_OFF = 3;
  localparam int unsigned EV_RST = 4;
  localparam int unsigned EV_W = 5;

  // State register fields
  localparam int unsigned ST_QUAL_LSB = 0;
  localparam int unsigned ST_IN_LSB = 4;
  localparam int unsigned ST_IND_LSB = 8;
  localparam int unsigned ST_DIS_BIT = 11;

  // ----------------------------------------
  // Function codes
  // ----------------------------------------
  localparam logic [3:0] FN_OFF = 4'h0;
  localparam logic [3:0] FN_AUX_NO = 4'h3;
  localparam logic [3:0] FN_AUX_NC = 4'h4;
  localparam logic [3:0] FN_DIS_NO = 4'h5;
  localparam logic [3:0] FN_DIS_NC = 4'h6;
  localparam logic [3:0] FN_DISR_NO = 4'h7;
  localparam logic [3:0] FN_DISR_NC = 4'h8;
  localparam logic [3:0] FN_RST_NO = 4'h9;

  typedef struct packed {
    logic aux;
    logic dis;
    logic rst;
    logic inv;
  } func_t;

  typedef struct packed {
    logic motor_disable;
    logic system_disabled_indication;
    logic fault_reset;
    logic [2:0] auxiliary_setpoint_indication;
    logic [15:0] setpoint;
  } ctrl_out_t;

  // Codes this block does not serve decode to all zero
  function automatic func_t decode(input logic [3:0] code);
    func_t f;
    f = '0;
    case (code)
      FN_AUX_NO: f.aux = 1'b1;
      FN_AUX_NC: begin
        f.aux = 1'b1;
        f.inv = 1'b1;
      end
      FN_DIS_NO: f.dis = 1'b1;
      FN_DIS_NC: begin
        f.dis = 1'b1;
        f.inv = 1'b1;
      end
      FN_DISR_NO: begin
        f.dis = 1'b1;
        f.rst = 1'b1;
      end
      FN_DISR_NC: begin
        f.dis = 1'b1;
        f.rst = 1'b1;
        f.inv = 1'b1;
      end
      FN_RST_NO: f.rst = 1'b1;
      default: f = '0;
    endcase
    return f;
  endfunction : decode

endpackage : aux_pkg

//--- core/persist_qual.sv
`timescale 1ns/1ps
`default_nettype none
module persist_qual (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic tick,
  input wire logic clr,
  input wire logic raw,
  output logic qual
);

  logic [aux_pkg::QCNT_W-1:0] cnt;
  logic [aux_pkg::QCNT_W-1:0] next_cnt;
  logic next_qual;
  localparam logic [aux_pkg::QCNT_W-1:0] LAST = aux_pkg::QCNT_W'(aux_pkg::QUAL_TICKS - 1);

  always_comb begin
    next_cnt = cnt;
    next_qual = qual;
    // RL2 ignore unused input
    if (clr) begin
      next_cnt = '0;
      next_qual = 1'b0;
    // RL17 restart on agreement
    end else if (raw == qual) begin
      next_cnt = '0;
    // RL6 RL7 one second held
    end else if (tick) begin
      if (cnt == LAST) begin
        next_cnt = '0;
        next_qual = raw;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      qual <= 1'b0;
    end else if (ce) begin
      cnt <= next_cnt;
      qual <= next_qual;
    end
  end

  property p_qual_change;
    @(posedge pclk) disable iff (!presetn)
    (ce && !clr && tick && cnt == LAST && raw != qual) |=> (qual == $past(raw));
  endproperty
  a_qual_change: assert property (p_qual_change) else $error("qualified level not taken"); // RL6
  property p_no_early;
    @(posedge pclk) disable iff (!presetn)
    ($changed(qual) && !$past(clr)) |-> $past(tick && cnt == LAST);
  endproperty
  a_no_early: assert property (p_no_early) else $error("level changed before one second"); // RL7
  property p_clr;
    @(posedge pclk) disable iff (!presetn)
    (ce && clr) |=> (!qual && cnt == '0);
  endproperty
  a_clr: assert property (p_clr) else $error("ignored input still qualified"); // RL2
  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (ce && !clr && raw == qual) |=> (cnt == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted"); // RL17

endmodule : persist_qual
`default_nettype wire

//--- dv/contact_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end input unit: contact levels change only just after a clock edge
module contact_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] level_cmd,
  output logic [3:0] contacts
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contacts <= 4'h0;
    end else begin
      contacts <= level_cmd;
    end
  end
endmodule : contact_unit
`default_nettype wire

//--- dv/aux_input_setpoint_disable_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module aux_input_setpoint_disable_logic_test;
  typedef struct {
    string name;
    int kind;
    logic [32:0] exp;
  } note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [3:0] contacts;
  logic [3:0] level_cmd = 4'h0;
  aux_pkg::ctrl_out_t control;
  aux_pkg::ctrl_out_t seen;
  logic look = 1'b0;
  logic [31:0] fr_cnt = 32'h00000000;
  note_t notes[$];
  note_t n;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 39;
  logic [31:0] r;
  logic [15:0] main_sp;
  logic [15:0] aux2;
  logic [15:0] aux3;

  // One second is 1000 ticks of 4 cycles here
  aux_input_ctrl #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auxiliary_contact_inputs(contacts), .control(control), .irq(irq));
  contact_unit far_end (.pclk(pclk), .presetn(presetn), .level_cmd(level_cmd),
    .contacts(contacts));

  initial begin
    forever #25 pclk = ~pclk;
  end

  task check(input string what, input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  always @(posedge pclk) begin
    if (control.fault_reset === 1'b1) fr_cnt <= fr_cnt + 1;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n = notes.pop_front();
      check(n.name, {pslverr, prdata}, n.exp);
    end
    if (look) begin
      n = notes.pop_front();
      seen = control;
      seen.fault_reset = 1'b0;
      if (n.kind == 1) check(n.name, {11'h000, seen}, n.exp);
      else check(n.name, {irq, fr_cnt}, n.exp);
    end
  end

  // Hang guard, well above the roughly 31k cycles of the sequence
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm,
    input logic [32:0] e);
    if (!w) notes.push_back('{nm, 0, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, "", 33'h000000000);
  endtask : wr

  task rd(input string nm, input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h00000000, nm, e);
  endtask : rd

  task look_at(input int k, input string nm, input logic [32:0] e);
    notes.push_back('{nm, k, e});
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
    @(posedge pclk);
  endtask : look_at

  task ctl(input string nm, input logic md, input logic [2:0] ind, input logic [15:0] sp);
    look_at(1, nm, {11'h000, md, md, 1'b0, ind, sp});
  endtask : ctl

  task idle(input int c);
    repeat (c) @(posedge pclk);
  endtask : idle

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    idle(20);
    presetn <= 1'b1;
    rd("func_sel reset", aux_pkg::ADDR_FUNC_SEL, 33'h000000000);
    rd("mask reset", aux_pkg::ADDR_MASK, 33'h000000000);
    rd("state reset", aux_pkg::ADDR_STATE, 33'h000000000);
    rd("unmapped", 8'h24, 33'h100000000);
    rd("misaligned", 8'h02, 33'h100000000);
    ctl("control reset", 1'b0, 3'h0, 16'h0000);
    look_at(2, "irq reset", 33'h000000000);
    r = $random(seed);
    aux3 = {1'b0, r[14:0]};
    aux2 = aux3 + 16'h0100;
    main_sp = r[31:16];
    wr(aux_pkg::ADDR_MAIN_SP, {16'h0000, main_sp});
    wr(aux_pkg::ADDR_AUX_SP0 + 8'h04, {16'h0000, aux2});
    wr(aux_pkg::ADDR_AUX_SP0 + 8'h08, {16'h0000, aux3});
    wr(aux_pkg::ADDR_MASK, 32'h00000001);
    // Input 1 off, input 2 present-active, input 3 absent-active
    wr(aux_pkg::ADDR_FUNC_SEL, 32'h00000430);
    level_cmd <= 4'b0111;
    idle(3900);
    ctl("aux early", 1'b0, 3'h0, main_sp);
    idle(200);
    ctl("aux on", 1'b0, 3'h2, aux2);
    look_at(2, "irq aux on", 33'h100000000);
    rd("status aux on", aux_pkg::ADDR_STATUS, 33'h000000001);
    look_at(2, "irq cleared", 33'h000000000);
    level_cmd <= 4'b0011;
    idle(4100);
    ctl("lowest wins", 1'b0, 3'h3, aux3);
    level_cmd <= 4'b0101;
    idle(3900);
    ctl("aux held", 1'b0, 3'h3, aux3);
    idle(200);
    ctl("main back", 1'b0, 3'h0, main_sp);
    level_cmd <= 4'b1000;
    idle(2);
    // Input 1 disables with fault reset, input 4 disables when absent
    wr(aux_pkg::ADDR_FUNC_SEL, 32'h00006007);
    level_cmd <= 4'b1001;
    idle(2000);
    level_cmd <= 4'b1000;
    idle(10);
    level_cmd <= 4'b1001;
    idle(3900);
    ctl("glitch restart", 1'b0, 3'h0, main_sp);
    idle(200);
    ctl("disabled", 1'b1, 3'h0, main_sp);
    look_at(2, "reset pulse masked irq", 33'h000000001);
    level_cmd <= 4'b0000;
    idle(4100);
    ctl("other input holds", 1'b1, 3'h0, main_sp);
    level_cmd <= 4'b1000;
    idle(3900);
    ctl("still disabled", 1'b1, 3'h0, main_sp);
    idle(200);
    ctl("re-enabled", 1'b0, 3'h0, main_sp);
    look_at(2, "no reset code 6", 33'h000000001);
    rd("status disable", aux_pkg::ADDR_STATUS, 33'h00000001e);
    wr(aux_pkg::ADDR_MASK, 32'h00000011);
    wr(aux_pkg::ADDR_FUNC_SEL, 32'h00000090);
    level_cmd <= 4'b1010;
    idle(4100);
    ctl("reset only", 1'b0, 3'h0, main_sp);
    look_at(2, "reset pulse", 33'h100000002);
    rd("state word", aux_pkg::ADDR_STATE, 33'h0000000a2);
    tally_and_finish();
  end
endmodule : aux_input_setpoint_disable_logic_test
`default_nettype wire
